// ===== verilog/accumulator_compare_unit.sv
// Accumulator compare datapath with APB registers and interrupt
`timescale 1ns/100ps
module accumulator_compare_unit #(
   parameter int unsigned STACK_DEPTH = 8,
   parameter int unsigned MEM_WORDS = 4096
) (
   input wire logic clk,
   input wire logic rstn,
   input wire cmp_pkg::apb_req_t apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic less_than_flag,
   output logic equal_flag,
   output logic greater_than_flag,
   output logic bad_pointer_flag,
   output logic non_real_operand_flag
);
   import cmp_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (STACK_DEPTH < 1 || STACK_DEPTH > 64) begin : g_bad_depth
      $error("STACK_DEPTH must lie in 1..64");
   end
   if (MEM_WORDS < 2 || MEM_WORDS > 65536) begin : g_bad_mem
      $error("MEM_WORDS must lie in 2..65536");
   end

   localparam logic [31:0] PTR_LIMIT = 32'(MEM_WORDS - 1);

   logic [31:0] acc_reg;
   logic [31:0] opnd_reg;
   logic [63:0] img_reg;
   logic [31:0] ptr_reg;
   logic [31:0] stack_reg [STACK_DEPTH];
   rel_t rel_reg;
   rel_t rel_next;
   err_t err_reg;
   err_t err_next;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_set;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;
   logic wr_fire;
   logic mapped;
   logic cmd_go;
   cmp_op_t op;
   logic ptr_mode;
   logic [4:0] cnt_m1;
   logic [5:0] start;
   logic [31:0] run_val;
   logic [31:0] operand;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Writes take effect only on the access edge with pready; reads are sampled at setup
   assign wr_fire = apb.psel && apb.penable && pready_reg && apb.pwrite;
   assign cmd_go = wr_fire && apb.paddr == CMD_OFS;
   assign op = cmp_op_t'(apb.pwdata[CMD_OP_LSB +: 2]);
   assign ptr_mode = apb.pwdata[CMD_PTR_BIT];
   assign cnt_m1 = apb.pwdata[CMD_CNT_LSB +: 5];
   assign start = apb.pwdata[CMD_START_LSB +: 6];

   always_comb begin
      unique case (apb.paddr)
         ACC_OFS, OPND_OFS, IMG_LO_OFS, IMG_HI_OFS, PTR_OFS, CMD_OFS,
         FLAGS_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS, STACK_TOP_OFS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Operand formation
   // ----------------------------------------------------------------
   // Run of discrete bits, first location lands in bit 0
   always_comb begin
      logic [63:0] shifted;
      logic [31:0] keep;
      shifted = img_reg >> start;
      keep = 32'hffff_ffff >> (5'd31 - cnt_m1);
      run_val = shifted[31:0] & keep;
   end

   // Binary or BCD both compare as plain magnitude, no decode needed
   always_comb begin
      unique case (op)
         OP_DWORD: operand = opnd_reg;
         OP_BITRUN: operand = run_val;
         OP_STACK: operand = stack_reg[0];
         OP_FLOAT: operand = opnd_reg;
      endcase
   end

   // ----------------------------------------------------------------
   // Relation and error outcome
   // ----------------------------------------------------------------
   function automatic rel_t mag_rel(logic [31:0] a, logic [31:0] b);
      rel_t r;
      r.lt = a < b;
      r.eq = a == b;
      r.gt = a > b;
      return r;
   endfunction

   // Sign-magnitude order; plus and minus zero count as equal
   function automatic rel_t float_rel(logic [31:0] a, logic [31:0] b);
      rel_t r;
      logic both_zero;
      both_zero = a[30:0] == 31'h0 && b[30:0] == 31'h0;
      if (both_zero || a == b) begin
         r = 3'b010;
      end else if (a[31] != b[31]) begin
         r = a[31] ? 3'b100 : 3'b001;
      end else if (a[31]) begin
         r = mag_rel(b, a);
      end else begin
         r = mag_rel(a, b);
      end
      return r;
   endfunction

   function automatic logic not_real(logic [31:0] v);
      return v[30:23] == FLOAT_EXP_MAX;
   endfunction

   always_comb begin
      rel_next = rel_reg;
      err_next = err_reg;
      if (cmd_go) begin
         if (op == OP_FLOAT) begin
            err_next.bad_ptr = ptr_mode && ptr_reg >= PTR_LIMIT;
            err_next.non_real = not_real(acc_reg) ||
                                not_real(opnd_reg);
            // No order exists for a faulty operand, all three clear
            if (err_next.bad_ptr || err_next.non_real) begin
               rel_next = 3'b000;
            end else begin
               rel_next = float_rel(acc_reg, operand);
            end
         end else begin
            rel_next = mag_rel(acc_reg, operand);
         end
      end
   end

   // Flags change only when a compare drives them
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rel_reg <= RST_REL;
         err_reg <= RST_ERR;
      end else begin
         rel_reg <= rel_next;
         err_reg <= err_next;
      end
   end

   // ----------------------------------------------------------------
   // Accumulator and stack
   // ----------------------------------------------------------------
   // Only a load write touches the accumulator, never a compare
   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc_reg <= RST_WORD;
      end else if (wr_fire && apb.paddr == ACC_OFS) begin
         acc_reg <= apb.pwdata;
      end
   end

   // Deepest entry falls off the bottom when the stack is full
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_reg[i] <= RST_WORD;
         end
      end else if (wr_fire && apb.paddr == ACC_OFS) begin
         stack_reg[0] <= acc_reg;
         for (int i = 1; i < STACK_DEPTH; i++) begin
            stack_reg[i] <= stack_reg[i-1];
         end
      end
   end

   // Operand, bit image and pointer registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         opnd_reg <= RST_WORD;
         img_reg <= {RST_WORD, RST_WORD};
         ptr_reg <= RST_WORD;
      end else if (wr_fire) begin
         if (apb.paddr == OPND_OFS) begin
            opnd_reg <= apb.pwdata;
         end
         if (apb.paddr == IMG_LO_OFS) begin
            img_reg[31:0] <= apb.pwdata;
         end
         if (apb.paddr == IMG_HI_OFS) begin
            img_reg[63:32] <= apb.pwdata;
         end
         if (apb.paddr == PTR_OFS) begin
            ptr_reg <= apb.pwdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   // Error events fire only on a float compare, never on held flags
   assign irq_set = {cmd_go && op == OP_FLOAT && err_next.non_real,
                     cmd_go && op == OP_FLOAT && err_next.bad_ptr,
                     cmd_go};

   // Set beats a same-cycle write-one clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_stat_reg <= RST_IRQ;
         irq_mask_reg <= RST_IRQ;
      end else begin
         if (wr_fire && apb.paddr == IRQ_STAT_OFS) begin
            irq_stat_reg <= (irq_stat_reg & ~apb.pwdata[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
         end
         if (wr_fire && apb.paddr == IRQ_MASK_OFS) begin
            irq_mask_reg <= apb.pwdata[IRQ_W-1:0];
         end
      end
   end

   // Registered output, one cycle behind the status bits
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // One wait-free access phase; read data sampled at setup
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= RST_WORD;
      end else begin
         pready_reg <= apb.psel && !apb.penable;
         pslverr_reg <= apb.psel && !apb.penable && !mapped;
         if (apb.psel && !apb.penable && !apb.pwrite) begin
            unique case (apb.paddr)
               ACC_OFS: prdata_reg <= acc_reg;
               OPND_OFS: prdata_reg <= opnd_reg;
               IMG_LO_OFS: prdata_reg <= img_reg[31:0];
               IMG_HI_OFS: prdata_reg <= img_reg[63:32];
               PTR_OFS: prdata_reg <= ptr_reg;
               FLAGS_OFS: prdata_reg <= {27'h0, err_reg, rel_reg};
               IRQ_STAT_OFS: prdata_reg <= {29'h0, irq_stat_reg};
               IRQ_MASK_OFS: prdata_reg <= {29'h0, irq_mask_reg};
               STACK_TOP_OFS: prdata_reg <= stack_reg[0];
               default: prdata_reg <= RST_WORD;
            endcase
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
   assign less_than_flag = rel_reg.lt;
   assign equal_flag = rel_reg.eq;
   assign greater_than_flag = rel_reg.gt;
   assign bad_pointer_flag = err_reg.bad_ptr;
   assign non_real_operand_flag = err_reg.non_real;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [31:0] acc_q;
   logic [31:0] opnd_q;
   always_ff @(posedge clk) begin
      acc_q <= acc_reg;
      opnd_q <= opnd_reg;
   end

   property p_dword_lt;
      @(posedge clk) disable iff (!rstn)
      cmd_go && op == OP_DWORD && acc_reg < opnd_reg |=> less_than_flag;
   endproperty
   a_dword_lt: assert property (p_dword_lt)
      else $error("less flag missing after double-word compare");

   property p_eq;
      @(posedge clk) disable iff (!rstn)
      cmd_go && op != OP_FLOAT && acc_reg == operand |=> equal_flag;
   endproperty
   a_eq: assert property (p_eq)
      else $error("equal flag missing after compare");

   property p_gt;
      @(posedge clk) disable iff (!rstn)
      cmd_go && op != OP_FLOAT && acc_reg > operand
      |=> greater_than_flag && !less_than_flag;
   endproperty
   a_gt: assert property (p_gt)
      else $error("greater flag wrong after compare");

   property p_hold;
      @(posedge clk) disable iff (!rstn)
      !cmd_go |=> $stable(rel_reg) && $stable(err_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("flags changed without a compare");

   property p_run_width;
      @(posedge clk) disable iff (!rstn)
      cmd_go && op == OP_BITRUN && cnt_m1 == 5'd3 && acc_reg > 32'h0000_000f
      |=> greater_than_flag;
   endproperty
   a_run_width: assert property (p_run_width)
      else $error("four-bit run not zero-extended");

   property p_stack_keep;
      @(posedge clk) disable iff (!rstn)
      cmd_go && op == OP_STACK |=> acc_reg == acc_q;
   endproperty
   a_stack_keep: assert property (p_stack_keep)
      else $error("stack compare altered accumulator");

   property p_push;
      @(posedge clk) disable iff (!rstn)
      wr_fire && apb.paddr == ACC_OFS |=> stack_reg[0] == acc_q;
   endproperty
   a_push: assert property (p_push)
      else $error("previous accumulator not pushed");

   property p_float_sign;
      @(posedge clk) disable iff (!rstn)
      cmd_go && op == OP_FLOAT && !ptr_mode && !not_real(acc_reg) &&
      !not_real(opnd_reg) && acc_reg[31] && !opnd_reg[31] &&
      (acc_reg[30:0] != 31'h0 || opnd_reg[30:0] != 31'h0)
      |=> less_than_flag;
   endproperty
   a_float_sign: assert property (p_float_sign)
      else $error("negative float not below positive float");

   property p_bad_ptr;
      @(posedge clk) disable iff (!rstn)
      cmd_go && op == OP_FLOAT && ptr_mode && ptr_reg >= PTR_LIMIT
      |=> bad_pointer_flag && irq_stat_reg[IRQ_BADPTR];
   endproperty
   a_bad_ptr: assert property (p_bad_ptr)
      else $error("invalid pointer not flagged");

   property p_non_real;
      @(posedge clk) disable iff (!rstn)
      cmd_go && op == OP_FLOAT && opnd_reg[30:23] == FLOAT_EXP_MAX
      |=> non_real_operand_flag && rel_reg == 3'b000;
   endproperty
   a_non_real: assert property (p_non_real)
      else $error("non-real operand not flagged");

   property p_onehot;
      @(posedge clk) disable iff (!rstn)
      $rose(|rel_reg) || $changed(rel_reg) && rel_reg != 3'b000
      |-> $onehot(rel_reg);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("relation flags not exclusive");

   c_dword: cover property (@(posedge clk) cmd_go && op == OP_DWORD);
   c_run32: cover property (@(posedge clk)
      cmd_go && op == OP_BITRUN && cnt_m1 == 5'd31);
   c_stack: cover property (@(posedge clk) cmd_go && op == OP_STACK);
   c_float_err: cover property (@(posedge clk)
      cmd_go && op == OP_FLOAT ##1 non_real_operand_flag);
endmodule // accumulator_compare_unit

// ===== verilog/cmp_pkg.sv
// Constants, types and register map of the accumulator compare unit
package cmp_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ACC_OFS = 8'h00;
   localparam logic [7:0] OPND_OFS = 8'h04;
   localparam logic [7:0] IMG_LO_OFS = 8'h08;
   localparam logic [7:0] IMG_HI_OFS = 8'h0c;
   localparam logic [7:0] PTR_OFS = 8'h10;
   localparam logic [7:0] CMD_OFS = 8'h14;
   localparam logic [7:0] FLAGS_OFS = 8'h18;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h1c;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
   localparam logic [7:0] STACK_TOP_OFS = 8'h24;
   // ----------------------------------------------------------------
   // Command word fields
   // ----------------------------------------------------------------
   localparam int unsigned CMD_OP_LSB = 0;
   localparam int unsigned CMD_PTR_BIT = 2;
   localparam int unsigned CMD_CNT_LSB = 3;
   localparam int unsigned CMD_START_LSB = 8;
   // ----------------------------------------------------------------
   // Interrupt status bits, reset values, float encoding
   // ----------------------------------------------------------------
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_BADPTR = 1;
   localparam int unsigned IRQ_NONREAL = 2;
   localparam int unsigned IRQ_W = 3;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
   localparam logic [7:0] FLOAT_EXP_MAX = 8'hff;
   localparam int unsigned MAX_RUN = 32;

   typedef enum logic [1:0] {
      OP_DWORD = 2'h0,
      OP_BITRUN = 2'h1,
      OP_STACK = 2'h2,
      OP_FLOAT = 2'h3
   } cmp_op_t;

   typedef struct packed {
      logic lt;
      logic eq;
      logic gt;
   } rel_t;

   typedef struct packed {
      logic bad_ptr;
      logic non_real;
   } err_t;

   typedef struct packed {
      logic [7:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
      logic psel;
      logic penable;
   } apb_req_t;

   localparam rel_t RST_REL = 3'h0;
   localparam err_t RST_ERR = 2'h0;
endpackage

// ===== verif/sequencer_model.sv
// Instruction sequencer model: APB master issuing register transfers
`timescale 1ns/100ps
module sequencer_model (
   input wire logic clk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output cmp_pkg::apb_req_t apb
);
   import cmp_pkg::*;

   // Bus idle from time zero
   initial apb = '0;

   // ----------------------------------------------------------------
   // One transfer: setup, access until pready, then release
   // ----------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      @(posedge clk);
      apb <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
      @(posedge clk);
      apb.penable <= 1'b1;
      // No wait count assumed; the bench timeout cuts a hang
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata; // Taken at the accepting edge, before later commands
      e = pslverr;
      // Released lines show inverted values, not stale ones
      apb <= '{paddr: ~a, pwrite: ~w, pwdata: ~d, psel: 1'b0,
               penable: 1'b0};
   endtask
endmodule // sequencer_model

// ===== verif/accumulator_compare_unit_bench.sv
// Self-checking bench for the accumulator compare unit
`timescale 1ns/100ps
module accumulator_compare_unit_bench;
   import cmp_pkg::*;

   typedef struct packed {
      logic [31:0] acc;
      logic [31:0] opnd;
      logic [7:0] ptr;
      logic [15:0] cmd;
      logic [4:0] fl;
   } row_t;

   // Flags {bad_ptr, non_real, lt, eq, gt}; both values same coding
   localparam row_t ROWS [18] = '{
      '{32'h00000005, 32'h00000006, 8'h00, 16'h0000, 5'h04},
      '{32'hffffffff, 32'hffffffff, 8'h00, 16'h0000, 5'h02},
      '{32'hffffffff, 32'h00000000, 8'h00, 16'h0000, 5'h01},
      '{32'h99999999, 32'h12345678, 8'h00, 16'h0000, 5'h01},
      '{32'h00000006, 32'h00000000, 8'h00, 16'h2019, 5'h04},
      '{32'h89abcdef, 32'h00000000, 8'h00, 16'h00f9, 5'h02},
      '{32'h00000001, 32'h00000000, 8'h00, 16'h0401, 5'h01},
      '{32'h40e00000, 32'h40c00000, 8'h00, 16'h0003, 5'h01},
      '{32'hbf800000, 32'h3f800000, 8'h00, 16'h0003, 5'h04},
      '{32'hc0000000, 32'hbf800000, 8'h00, 16'h0003, 5'h04},
      '{32'h00000000, 32'h80000000, 8'h00, 16'h0003, 5'h02},
      '{32'h40e00000, 32'h40c00000, 8'h0e, 16'h0007, 5'h01},
      '{32'h40e00000, 32'h40c00000, 8'h0f, 16'h0007, 5'h10},
      '{32'h00000003, 32'h00000003, 8'h00, 16'h0000, 5'h12},
      '{32'h7f800000, 32'h3f800000, 8'h00, 16'h0003, 5'h08},
      '{32'h3f800000, 32'h7fc00000, 8'h00, 16'h0003, 5'h08},
      '{32'h3f800000, 32'h3f800000, 8'h00, 16'h0003, 5'h02},
      '{32'h00000010, 32'h00000000, 8'h00, 16'h0019, 5'h01}
   };
   localparam int LIMIT = 4000;

   logic clk;
   logic rstn;
   apb_req_t apb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic lt_o;
   logic eq_o;
   logic gt_o;
   logic bad_o;
   logic nr_o;
   logic [31:0] rdat;
   logic rerr;
   int failures = 0;
   int checks = 0;
   int cyc = 0;

   // Small memory so the pointer limit is reachable
   accumulator_compare_unit #(.STACK_DEPTH(8), .MEM_WORDS(16)) DUT (
      .clk(clk), .rstn(rstn), .apb(apb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .less_than_flag(lt_o), .equal_flag(eq_o),
      .greater_than_flag(gt_o), .bad_pointer_flag(bad_o),
      .non_real_operand_flag(nr_o)
   );

   sequencer_model seq (
      .clk(clk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .apb(apb)
   );

   // ----------------------------------------------------------------
   // Clock, timeout and reporting
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard, well above the few hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (failures == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      seq.xfer(1'b1, a, d, rdat, rerr);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      seq.xfer(1'b0, a, 32'h0, rdat, rerr);
      chk(rdat, e);
   endtask

   // Pins {irq, bad_ptr, non_real, lt, eq, gt} after edges settle
   task automatic outs_chk(input logic [5:0] e);
      @(negedge clk);
      chk({26'h0, irq, bad_o, nr_o, lt_o, eq_o, gt_o}, {26'h0, e});
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      outs_chk(6'h00);
      for (int i = 0; i < 10; i++) rd_chk(8'(4 * i), 32'h0);
      wr(FLAGS_OFS, 32'h1f); // Read-only flags ignore writes
      rd_chk(FLAGS_OFS, 32'h0);
      wr(IMG_LO_OFS, 32'h89abcdef);
      wr(IMG_HI_OFS, 32'h0000000e);
      for (int i = 0; i < 18; i++) begin
         wr(PTR_OFS, {24'h0, ROWS[i].ptr});
         wr(ACC_OFS, ROWS[i].acc);
         wr(OPND_OFS, ROWS[i].opnd);
         wr(CMD_OFS, {16'h0, ROWS[i].cmd});
         outs_chk({1'b0, ROWS[i].fl});
         rd_chk(FLAGS_OFS, {27'h0, ROWS[i].fl});
      end
      // Stack: second load pushes the first, compare does not pop
      wr(ACC_OFS, 32'h00000005);
      wr(ACC_OFS, 32'h00000009);
      rd_chk(STACK_TOP_OFS, 32'h00000005);
      wr(CMD_OFS, 32'h00000002);
      outs_chk(6'h01);
      rd_chk(ACC_OFS, 32'h00000009);
      rd_chk(STACK_TOP_OFS, 32'h00000005);
      wr(ACC_OFS, 32'h00000002);
      rd_chk(FLAGS_OFS, 32'h00000001);
      wr(CMD_OFS, 32'h00000002);
      outs_chk(6'h04);
      // Interrupt: sticky done bit, masked, unmasked, cleared
      rd_chk(IRQ_STAT_OFS, 32'h7);
      wr(IRQ_STAT_OFS, 32'h7);
      rd_chk(IRQ_STAT_OFS, 32'h0);
      wr(CMD_OFS, 32'h00000002);
      rd_chk(IRQ_STAT_OFS, 32'h1);
      outs_chk(6'h04);
      wr(IRQ_MASK_OFS, 32'h1);
      @(posedge clk);
      outs_chk(6'h24);
      rd_chk(IRQ_MASK_OFS, 32'h1);
      wr(IRQ_STAT_OFS, 32'h1);
      @(posedge clk);
      outs_chk(6'h04);
      // Unmapped place: error response, reads zero
      seq.xfer(1'b0, 8'h3c, 32'h0, rdat, rerr);
      chk(rdat, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      seq.xfer(1'b1, 8'h3c, 32'h5, rdat, rerr);
      chk({31'h0, rerr}, 32'h1);
      // Reset in mid-run clears flags, accumulator and stack
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      outs_chk(6'h00);
      @(posedge clk);
      rstn <= 1'b1;
      rd_chk(ACC_OFS, 32'h0);
      rd_chk(STACK_TOP_OFS, 32'h0);
      give_verdict();
   end
endmodule // accumulator_compare_unit_bench
